// file: rtl/pif_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants for the id and event flag block
// ****************************************************************
package pif_pkg;
    // port widths and register subaddresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] SUB_ID = 8'h00;
    localparam logic [7:0] SUB_FLAG1 = 8'h01;
    localparam logic [7:0] SUB_FLAG2 = 8'h02;
    localparam logic [7:0] SUB_MASK1 = 8'h03;
    localparam logic [7:0] SUB_MASK2 = 8'h04;

    // field layout: six flag bits in the low end, two reserved above
    localparam int FLAG_W = 6;
    localparam logic [1:0] RSVD_VAL = 2'h0;
    localparam logic [5:0] FLAG_RST = 6'h00;
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [7:0] RD_NONE = 8'h00;

    // primary flag bit positions
    localparam int F1_PROG_LOW = 5;
    localparam int F1_ADAPTER = 4;
    localparam int F1_BUTTON = 3;
    localparam int F1_THERMAL = 2;
    localparam int F1_CELL = 1;
    localparam int F1_COMMIT = 0;

    // switch flag bit positions
    localparam int F2_SW3_FAULT = 5;
    localparam int F2_SW2_FAULT = 4;
    localparam int F2_SW1_FAULT = 3;
    localparam int F2_SW3_LIMIT = 2;
    localparam int F2_SW2_LIMIT = 1;
    localparam int F2_SW1_LIMIT = 0;

    // bits that follow a live condition instead of latching
    localparam logic [5:0] F1_LEVEL_BITS = 6'h04;
    localparam logic [5:0] F2_LEVEL_BITS = 6'h07;

    // identification fields, values arbitrary
    localparam logic [4:0] PART_CODE_DEF = 5'h0A;
    localparam logic [2:0] SILICON_VERSION_DEF = 3'h2;

    // commit sequencer states
    typedef enum logic [0:0] {
        PIF_CMT_IDLE = 1'b0,
        PIF_CMT_BUSY = 1'b1
    } pif_commit_e;
endpackage : pif_pkg
`default_nettype wire

// file: rtl/pif_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one bank of six flags with clear-on-read and mask gating
// ****************************************************************
module pif_flag_bank
    import pif_pkg::*;
#(
    parameter int W = FLAG_W,
    parameter logic [W-1:0] LEVEL_BITS = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] set_in,
    input wire logic clear,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] flags,
    output logic pending
);
    // whole state of the bank
    typedef struct packed {
        logic [W-1:0] flags;
    } pif_bank_s;

    pif_bank_s state_reg; // registered state
    pif_bank_s state_next; // next state
    logic [W-1:0] flags_next; // per-bit next value

    // per-bit update; set beats the clear of a read in the same cycle
    for (genvar i = 0; i < W; i++) begin : g_bit
        if (LEVEL_BITS[i]) begin : g_level
            // live indication, no memory
            assign flags_next[i] = set_in[i];
        end else begin : g_event
            // sticky until the host reads it
            assign flags_next[i] = set_in[i] | (state_reg.flags[i] & ~clear);
        end
    end

    // next state
    always_comb begin
        state_next = state_reg;
        state_next.flags = flags_next;
    end

    // state register, synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.flags <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;
    // mask only gates the request, the flag itself keeps working
    assign pending = |(state_reg.flags & ~mask);
endmodule : pif_flag_bank
`default_nettype wire

// file: rtl/pif_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pif_regs
    import pif_pkg::*;
#(
    parameter logic [4:0] PART_CODE = PART_CODE_DEF, // arbitrary value
    parameter logic [2:0] SILICON_VERSION = SILICON_VERSION_DEF // arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    // ****************************************************************
    // register access port
    // ****************************************************************
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // ****************************************************************
    // monitored conditions
    // ****************************************************************
    input wire logic adapter_detect_input,
    input wire logic button_input,
    input wire logic thermal_hot,
    input wire logic backup_cell_measure_done,
    input wire logic nvm_commit_req,
    input wire logic bias_supply_ok,
    input wire logic nvm_write_finished,
    input wire logic switch_one_overtemp,
    input wire logic switch_two_overtemp,
    input wire logic switch_two_undervolt,
    input wire logic switch_three_overtemp,
    input wire logic switch_one_limiting,
    input wire logic switch_two_limiting,
    input wire logic switch_three_limiting,
    // ****************************************************************
    // outputs
    // ****************************************************************
    output logic nvm_write_busy,
    output logic interrupt_out_n
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic primed; // edge history valid
        logic prev_adapter; // last adapter level
        logic prev_button; // last button level
        logic [FLAG_W-1:0] mask1; // primary masks
        logic [FLAG_W-1:0] mask2; // switch masks
        logic [DATA_W-1:0] rdata; // read data
        pif_commit_e commit; // commit sequencer
        logic irq_n; // interrupt pin
    } pif_state_s;

    pif_state_s state_reg; // registered state
    pif_state_s state_next; // next state

    logic [FLAG_W-1:0] set1; // primary set requests
    logic [FLAG_W-1:0] set2; // switch set requests
    logic [FLAG_W-1:0] flags1; // primary flags
    logic [FLAG_W-1:0] flags2; // switch flags
    logic pend1; // unmasked primary flag
    logic pend2; // unmasked switch flag
    logic clr1; // read of primary flags
    logic clr2; // read of switch flags
    logic prog_low_evt; // commit refused
    logic commit_done_evt; // commit finished

    // ****************************************************************
    // helpers
    // ****************************************************************
    // pad six flag bits into a byte with reserved zeros
    function automatic logic [DATA_W-1:0] pif_pack(input logic [FLAG_W-1:0] f);
        pif_pack = {RSVD_VAL, f};
    endfunction : pif_pack

    // address match used for reads and writes alike
    function automatic logic pif_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] sub);
        pif_hit = (a == sub);
    endfunction : pif_hit

    // ****************************************************************
    // commit request decision, combinational
    // ****************************************************************
    // a request while already busy is dropped; low bias refuses it
    always_comb begin
        prog_low_evt = 1'b0;
        if (nvm_commit_req && (state_reg.commit == PIF_CMT_IDLE) && !bias_supply_ok) begin
            prog_low_evt = 1'b1;
        end
        commit_done_evt = (state_reg.commit == PIF_CMT_BUSY) && nvm_write_finished;
    end

    // ****************************************************************
    // flag set requests
    // ****************************************************************
    always_comb begin
        set1 = FLAG_RST;
        set1[F1_PROG_LOW] = prog_low_evt;
        // no edge before the first sample after reset, avoids a false flag
        set1[F1_ADAPTER] = state_reg.primed && (adapter_detect_input != state_reg.prev_adapter);
        set1[F1_BUTTON] = state_reg.primed && (button_input != state_reg.prev_button);
        set1[F1_THERMAL] = thermal_hot;
        set1[F1_CELL] = backup_cell_measure_done;
        set1[F1_COMMIT] = commit_done_evt;
        set2 = FLAG_RST;
        set2[F2_SW3_FAULT] = switch_three_overtemp;
        set2[F2_SW2_FAULT] = switch_two_overtemp | switch_two_undervolt;
        set2[F2_SW1_FAULT] = switch_one_overtemp;
        set2[F2_SW3_LIMIT] = switch_three_limiting;
        set2[F2_SW2_LIMIT] = switch_two_limiting;
        set2[F2_SW1_LIMIT] = switch_one_limiting;
    end

    // a read clears its own register only
    assign clr1 = reg_rd && pif_hit(reg_addr, SUB_FLAG1);
    assign clr2 = reg_rd && pif_hit(reg_addr, SUB_FLAG2);

    // ****************************************************************
    // flag banks
    // ****************************************************************
    pif_flag_bank #(
        .W(FLAG_W),
        .LEVEL_BITS(F1_LEVEL_BITS)
    ) u_bank1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(set1),
        .clear(clr1),
        .mask(state_reg.mask1),
        .flags(flags1),
        .pending(pend1)
    );

    pif_flag_bank #(
        .W(FLAG_W),
        .LEVEL_BITS(F2_LEVEL_BITS)
    ) u_bank2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(set2),
        .clear(clr2),
        .mask(state_reg.mask2),
        .flags(flags2),
        .pending(pend2)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        // edge history
        state_next.primed = 1'b1;
        state_next.prev_adapter = adapter_detect_input;
        state_next.prev_button = button_input;
        // read data, captured before the clear lands
        if (reg_rd) begin
            case (reg_addr)
                SUB_ID: state_next.rdata = {PART_CODE, SILICON_VERSION};
                SUB_FLAG1: state_next.rdata = pif_pack(flags1);
                SUB_FLAG2: state_next.rdata = pif_pack(flags2);
                SUB_MASK1: state_next.rdata = pif_pack(state_reg.mask1);
                SUB_MASK2: state_next.rdata = pif_pack(state_reg.mask2);
                default: state_next.rdata = RD_NONE; // unmapped reads zero
            endcase
        end
        // mask writes; writes are ignored while a commit is running
        if (reg_wr && (state_reg.commit == PIF_CMT_IDLE)) begin
            if (pif_hit(reg_addr, SUB_MASK1)) begin
                state_next.mask1 = reg_wdata[FLAG_W-1:0];
            end
            if (pif_hit(reg_addr, SUB_MASK2)) begin
                state_next.mask2 = reg_wdata[FLAG_W-1:0];
            end
        end
        // commit sequencer
        case (state_reg.commit)
            PIF_CMT_IDLE: begin
                // only start with enough bias, else contents stay untouched
                if (nvm_commit_req && bias_supply_ok) begin
                    state_next.commit = PIF_CMT_BUSY;
                end
            end
            PIF_CMT_BUSY: begin
                if (nvm_write_finished) begin
                    state_next.commit = PIF_CMT_IDLE;
                end
            end
            default: state_next.commit = PIF_CMT_IDLE;
        endcase
        // pin is one cycle behind the flags, kept glitch free
        state_next.irq_n = ~(pend1 | pend2);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.primed <= 1'b0;
            state_reg.prev_adapter <= 1'b0;
            state_reg.prev_button <= 1'b0;
            state_reg.mask1 <= MASK_RST;
            state_reg.mask2 <= MASK_RST;
            state_reg.rdata <= RD_NONE;
            state_reg.commit <= PIF_CMT_IDLE;
            state_reg.irq_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = state_reg.rdata;
    assign nvm_write_busy = (state_reg.commit == PIF_CMT_BUSY);
    assign interrupt_out_n = state_reg.irq_n;
endmodule : pif_regs
`default_nettype wire

// file: bench/pif_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker for the id and flag block
// ****************************************************************
module pif_regs_chk
    import pif_pkg::*;
#(
    parameter logic [4:0] PART_CODE = PART_CODE_DEF,
    parameter logic [2:0] SILICON_VERSION = SILICON_VERSION_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic thermal_hot,
    input wire logic switch_one_limiting,
    input wire logic nvm_commit_req,
    input wire logic bias_supply_ok,
    input wire logic nvm_write_finished,
    input wire logic nvm_write_busy,
    input wire logic interrupt_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // any read of either flag bank
    wire logic flag_rd = reg_rd && (reg_addr == SUB_FLAG1 || reg_addr == SUB_FLAG2);
    // level bits lag the input by one cycle, rdata by one more
    id_read_a: assert property (reg_rd && reg_addr == SUB_ID |=> reg_rdata == {PART_CODE, SILICON_VERSION})
        else $error("id read wrong");
    rsvd_zero_a: assert property (flag_rd |=> reg_rdata[7:6] == RSVD_VAL)
        else $error("reserved flag bits not zero");
    thermal_live_a: assert property (reg_rd && reg_addr == SUB_FLAG1 |=> reg_rdata[2] == $past(thermal_hot, 2))
        else $error("thermal bit does not follow input");
    limit_live_a: assert property (reg_rd && reg_addr == SUB_FLAG2 |=> reg_rdata[0] == $past(switch_one_limiting, 2))
        else $error("limit bit does not follow input");
    commit_go_a: assert property (nvm_commit_req && !nvm_write_busy && bias_supply_ok |=> nvm_write_busy)
        else $error("commit did not start");
    commit_skip_a: assert property (nvm_commit_req && !nvm_write_busy && !bias_supply_ok |=> !nvm_write_busy)
        else $error("commit started on low bias");
    busy_end_a: assert property (nvm_write_busy && nvm_write_finished |=> !nvm_write_busy)
        else $error("busy outlived finish");
    // reset itself is checked here, so no disable
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> interrupt_out_n && reg_rdata == RD_NONE)
        else $error("outputs not quiet after reset");
    cover property (nvm_write_busy && nvm_write_finished);
    cover property ($fell(interrupt_out_n));
    cover property (reg_rd && reg_addr == SUB_FLAG2 ##1 reg_rdata != RD_NONE);
endmodule : pif_regs_chk
`default_nettype wire

// file: bench/pif_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host side of the register port
// ****************************************************************
module pif_host
    import pif_pkg::*;
(
    input wire logic clk,
    output logic reg_rd,
    output logic reg_wr,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // caller sits just after an edge; strobe held over one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a; // released: no stale address
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask : wr
endmodule : pif_host
`default_nettype wire

// file: bench/tb_pif_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the id and flag block
// ****************************************************************
module tb_pif_regs
    import pif_pkg::*;
;
    logic clk, sys_rst, req, bias, fin, reg_rd, reg_wr, busy, irq_n;
    logic [10:0] cond; // monitored conditions, one bit each
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    typedef struct packed {logic [10:0] cond; logic [7:0] addr; logic [7:0] exp; logic irq_n;} pif_row_s;
    // one condition or none held, one register read, expected pin level
    pif_row_s rows [13] = '{'{11'h001, 8'h01, 8'h10, 1'b0}, '{11'h002, 8'h01, 8'h08, 1'b0},
        '{11'h004, 8'h01, 8'h04, 1'b0}, '{11'h008, 8'h01, 8'h02, 1'b0}, '{11'h010, 8'h02, 8'h08, 1'b0},
        '{11'h020, 8'h02, 8'h10, 1'b0}, '{11'h040, 8'h02, 8'h10, 1'b0}, '{11'h080, 8'h02, 8'h20, 1'b0},
        '{11'h100, 8'h02, 8'h01, 1'b0}, '{11'h200, 8'h02, 8'h02, 1'b0}, '{11'h400, 8'h02, 8'h04, 1'b0},
        '{11'h000, 8'h00, {PART_CODE_DEF, SILICON_VERSION_DEF}, 1'b1}, '{11'h000, 8'h05, 8'h00, 1'b1}};
    pif_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adapter_detect_input(cond[0]), .button_input(cond[1]),
        .thermal_hot(cond[2]), .backup_cell_measure_done(cond[3]), .nvm_commit_req(req), .bias_supply_ok(bias),
        .nvm_write_finished(fin), .switch_one_overtemp(cond[4]), .switch_two_overtemp(cond[5]),
        .switch_two_undervolt(cond[6]), .switch_three_overtemp(cond[7]), .switch_one_limiting(cond[8]),
        .switch_two_limiting(cond[9]), .switch_three_limiting(cond[10]), .nvm_write_busy(busy),
        .interrupt_out_n(irq_n));
    pif_host host (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // drop all conditions and empty both banks
    task automatic clear();
        cond = 11'h000;
        tick(2);
        host.rd(SUB_FLAG1, d);
        tick(1);
        host.rd(SUB_FLAG2, d);
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
    endtask : clear
    task automatic give_verdict();
        if (num_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // a hang costs a mismatch, run is a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        sys_rst = 1'b1;
        cond = 11'h000;
        req = 1'b0;
        bias = 1'b1;
        fin = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (int a = 1; a < 5; a++) begin
            tick(1);
            host.rd(8'(a), d);
            chk(d, 8'h00);
        end
        foreach (rows[i]) begin
            cond = rows[i].cond;
            tick(2);
            chk({7'h00, irq_n}, {7'h00, rows[i].irq_n});
            host.rd(rows[i].addr, d);
            chk(d, rows[i].exp);
            clear();
        end
        // sticky change flag, cleared by its read
        cond[1] = 1'b1;
        tick(3);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h08);
        tick(1);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h00);
        clear();
        // mask write, read-only write, masked event
        host.wr(SUB_MASK1, 8'hFF);
        tick(1);
        host.rd(SUB_MASK1, d);
        chk(d, 8'h3F);
        // let an edge pass so the address is not driven twice in one step
        tick(1);
        host.wr(SUB_FLAG1, 8'hFF);
        tick(1);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h00);
        cond[1] = 1'b1;
        tick(3);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(SUB_MASK1, 8'h37);
        tick(2);
        chk({7'h00, irq_n}, 8'h00);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h08);
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(SUB_MASK1, 8'h00);
        clear();
        // commit with good bias, write ignored meanwhile
        req = 1'b1;
        tick(1);
        req = 1'b0;
        chk({7'h00, busy}, 8'h01);
        host.wr(SUB_MASK2, 8'hFF);
        fin = 1'b1;
        tick(1);
        fin = 1'b0;
        chk({7'h00, busy}, 8'h00);
        tick(1);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h01);
        tick(1);
        host.rd(SUB_MASK2, d);
        chk(d, 8'h00);
        // commit refused on low bias
        bias = 1'b0;
        req = 1'b1;
        tick(1);
        req = 1'b0;
        chk({7'h00, busy}, 8'h00);
        tick(1);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h20);
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
        // switch masks: write lands when idle, masked fault keeps the pin high
        host.wr(SUB_MASK2, 8'hFF);
        cond[4] = 1'b1;
        tick(3);
        chk({7'h00, irq_n}, 8'h01);
        host.rd(SUB_MASK2, d);
        chk(d, 8'h3F);
        // mid-run reset empties masks and outputs, held fault re-sets its flag
        sys_rst = 1'b1;
        tick(1);
        sys_rst = 1'b0;
        chk(reg_rdata, 8'h00);
        tick(1);
        host.rd(SUB_MASK2, d);
        chk(d, 8'h00);
        chk({7'h00, irq_n}, 8'h00);
        // event held through its clearing read: set wins, flag stays
        cond[3] = 1'b1;
        tick(1);
        host.rd(SUB_FLAG1, d);
        tick(1);
        host.rd(SUB_FLAG1, d);
        chk(d, 8'h02);
        give_verdict();
    end
endmodule : tb_pif_regs
bind pif_regs pif_regs_chk #(.PART_CODE(PART_CODE), .SILICON_VERSION(SILICON_VERSION)) u_chk (.clk(clk),
    .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .thermal_hot(thermal_hot),
    .switch_one_limiting(switch_one_limiting), .nvm_commit_req(nvm_commit_req), .bias_supply_ok(bias_supply_ok),
    .nvm_write_finished(nvm_write_finished), .nvm_write_busy(nvm_write_busy), .interrupt_out_n(interrupt_out_n));
`default_nettype wire
